// ==== pbc_regs.vh ====
// Purpose: Constants for the power state and boot control unit
// Assumes: 40 MHz clock
// Notes:   Included by every design file of the block except the wake synchroniser
`ifndef PBC_REGS_VH
`define PBC_REGS_VH

// ----------------------------------------------------------------------
// Power states
// ----------------------------------------------------------------------
`define PBC_ST_ACTIVE     3'h0
`define PBC_ST_ENTER      3'h1
`define PBC_ST_SLEEP      3'h2
`define PBC_ST_DEEP       3'h3
`define PBC_ST_WARM       3'h4

// ----------------------------------------------------------------------
// Boot phases
// ----------------------------------------------------------------------
`define PBC_BT_IDLE       3'h0
`define PBC_BT_APPLET     3'h1
`define PBC_BT_IMAGE      3'h2
`define PBC_BT_HANDOVER   3'h3
`define PBC_BT_RUN        3'h4

// ----------------------------------------------------------------------
// Serial pin sharing select
// ----------------------------------------------------------------------
`define PBC_SER_SPI       2'h0
`define PBC_SER_UART      2'h1
`define PBC_SER_GPIO      2'h2

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PBC_CLK_HZ        40000000
`define PBC_ENTER_MAX_S   1
`define PBC_ENTER_CYCLES  (`PBC_ENTER_MAX_S * `PBC_CLK_HZ)
`define PBC_WARM_CYCLES   64

`endif

// ==== pbc_wake_sync.v ====
// Purpose: Two-stage synchroniser with edge detect for one wake input
// Assumes: Single clock, asynchronous active-low reset
// Notes:   Only the second stage feeds the edge detector
`timescale 1ns/10ps
module pbc_wake_sync (
    // Clock and reset
    input  wire clock,
    input  wire rst_n,
    // Raw input and edge pulse
    input  wire raw_in,
    output reg  edge_pulse
);
    reg       meta_reg;
    reg       sync_reg;
    reg       last_reg;
    // Holds off detection until the pipe holds real pin values, so a high pin
    // at reset release is not taken for an edge
    reg [1:0] fill_reg;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg   <= 1'b0;
            sync_reg   <= 1'b0;
            last_reg   <= 1'b0;
            fill_reg   <= 2'h0;
            edge_pulse <= 1'b0;
        end else begin
            meta_reg   <= raw_in;
            sync_reg   <= meta_reg;
            last_reg   <= sync_reg;
            fill_reg   <= (fill_reg == 2'h3) ? 2'h3 : fill_reg + 2'h1;
            edge_pulse <= (fill_reg == 2'h3) && (sync_reg ^ last_reg);
        end
    end
endmodule // pbc_wake_sync

// ==== pbc_power_boot.v ====
// Purpose: Power state unit and boot source control
// Assumes: 40 MHz always-on clock, asynchronous active-low reset
// Notes:   Outputs are registered; the boot sequence runs once per reset
// Function
// RULE_01: Always-on island keeps running; gated island has its own power switch.
// RULE_02: Sleep stops clocks of low-power always-on part and gated island.
// RULE_03: Sleep keeps all powered, clocks gated; PHY off, MAC on.
// RULE_04: Sleep wakes on host command, timer, or general-purpose input edge.
// RULE_05: Deep sleep powers off all but this unit, SRAM, analog, few I/O.
// RULE_06: Deep sleep ignores host wake; only timer or input edge wakes.
// RULE_07: Leaving sleep performs warm boot starting at wake detection.
// RULE_08: Sleep entry completes within one second of the sleep request.
// RULE_09: Active state may drop to lower power on traffic or host message.
// RULE_10: Strap selects firmware image from boot flash or host download.
// RULE_11: Flash boot starts reading over master port right after reset.
// RULE_12: Host boot takes management message packets through the slave port.
// RULE_13: Boot loads applet, then firmware image, then hands over CPU.
// RULE_14: Master port has one chip select, used only for flash boot.
// RULE_15: Slave port, UART and shared pins are mutually exclusive.
// RULE_16: After reset the unit is active, all powered, clocks running.
// RULE_17: Wake inputs are synchronised before edge detection.
`timescale 1ns/10ps
`include "pbc_regs.vh"
module pbc_power_boot #(
    parameter         N_WAKE        = 4,
    parameter integer ENTER_CYCLES  = `PBC_ENTER_CYCLES,
    parameter integer WARM_CYCLES   = `PBC_WARM_CYCLES
) (
    // Clock and reset
    input  wire              clock,
    input  wire              rst_n,
    // Straps
    input  wire              strap_host_boot,
    input  wire [1:0]        strap_serial_sel,
    // Power requests
    input  wire              sleep_req,
    input  wire              deep_req,
    input  wire              traffic_idle,
    input  wire              enter_done,
    // Wake sources
    input  wire              host_wake,
    input  wire              timer_wake,
    input  wire [N_WAKE-1:0] wake_pin,
    // Boot progress
    input  wire              applet_done,
    input  wire              image_done,
    input  wire              mgmt_msg_valid,
    // Island control
    output reg               island_gated_pwr_on,
    output reg               lp_clk_en,
    output reg               gated_clk_en,
    output reg               phy_pwr_on,
    output reg               mac_pwr_on,
    output reg               sram_retain,
    // State and boot
    output reg  [2:0]        power_state,
    output reg  [2:0]        boot_phase,
    output reg               boot_from_flash,
    output reg               flash_cs_n,
    output reg               flash_fetch_en,
    output reg               mgmt_msg_accept,
    output reg               cpu_release,
    output reg               warm_boot,
    // Serial sharing
    output reg               ser_spi_en,
    output reg               ser_uart_en,
    output reg               ser_gpio_en
);
    // ------------------------------------------------------------------
    // Wake synchronisers
    // ------------------------------------------------------------------
    wire [N_WAKE-1:0] wake_edge;
    genvar gi;
    generate
        for (gi = 0; gi < N_WAKE; gi = gi + 1) begin : g_wake
            pbc_wake_sync u_sync (
                .clock      (clock),
                .rst_n      (rst_n),
                .raw_in     (wake_pin[gi]),
                .edge_pulse (wake_edge[gi])
            ); // RULE_17
        end
    endgenerate

    // ------------------------------------------------------------------
    // Power state machine
    // ------------------------------------------------------------------
    reg  [2:0]  state_reg;
    reg  [2:0]  state_next;
    reg         deep_pend_reg;
    reg         deep_pend_next;
    reg  [31:0] cnt_reg;
    reg  [31:0] cnt_next;
    reg         strap_done_reg;
    reg         host_reg;
    wire        any_edge = |wake_edge;
    wire        go_low   = sleep_req | deep_req | traffic_idle; // RULE_09

    always @* begin
        state_next     = state_reg;
        deep_pend_next = deep_pend_reg;
        cnt_next       = cnt_reg;
        case (state_reg)
            `PBC_ST_ACTIVE: begin
                if (go_low) begin
                    state_next     = `PBC_ST_ENTER;
                    deep_pend_next = deep_req;
                    cnt_next       = 32'h0000_0000;
                end
            end
            `PBC_ST_ENTER: begin
                // Forced at the deadline so a stuck quiesce cannot hold us awake
                if (enter_done || cnt_reg >= ENTER_CYCLES - 1) begin // RULE_08
                    state_next = deep_pend_reg ? `PBC_ST_DEEP : `PBC_ST_SLEEP;
                end else begin
                    cnt_next = cnt_reg + 32'h0000_0001;
                end
            end
            `PBC_ST_SLEEP: begin
                if (host_wake || timer_wake || any_edge) begin // RULE_04
                    state_next = `PBC_ST_WARM; // RULE_07
                    cnt_next   = 32'h0000_0000;
                end
            end
            `PBC_ST_DEEP: begin
                // Host wake deliberately not looked at here
                if (timer_wake || any_edge) begin // RULE_06
                    state_next = `PBC_ST_WARM; // RULE_07
                    cnt_next   = 32'h0000_0000;
                end
            end
            `PBC_ST_WARM: begin
                if (cnt_reg >= WARM_CYCLES - 1) begin
                    state_next = `PBC_ST_ACTIVE;
                end else begin
                    cnt_next = cnt_reg + 32'h0000_0001;
                end
            end
            default: state_next = `PBC_ST_ACTIVE;
        endcase
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg     <= `PBC_ST_ACTIVE; // RULE_16
            deep_pend_reg <= 1'b0;
            cnt_reg       <= 32'h0000_0000;
        end else begin
            state_reg     <= state_next;
            deep_pend_reg <= deep_pend_next;
            cnt_reg       <= cnt_next;
        end
    end

    // ------------------------------------------------------------------
    // Island controls
    // ------------------------------------------------------------------
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            island_gated_pwr_on <= 1'b1; // RULE_16
            lp_clk_en           <= 1'b1;
            gated_clk_en        <= 1'b1;
            phy_pwr_on          <= 1'b1;
            mac_pwr_on          <= 1'b1;
            sram_retain         <= 1'b0;
            power_state         <= `PBC_ST_ACTIVE;
            warm_boot           <= 1'b0;
        end else begin
            power_state         <= state_next;
            // Gated island loses power only in deep sleep
            island_gated_pwr_on <= (state_next != `PBC_ST_DEEP); // RULE_01 RULE_05
            lp_clk_en           <= (state_next != `PBC_ST_SLEEP) &&
                                   (state_next != `PBC_ST_DEEP); // RULE_02
            gated_clk_en        <= (state_next != `PBC_ST_SLEEP) &&
                                   (state_next != `PBC_ST_DEEP); // RULE_02 RULE_03
            phy_pwr_on          <= (state_next != `PBC_ST_SLEEP) &&
                                   (state_next != `PBC_ST_DEEP); // RULE_03
            mac_pwr_on          <= (state_next != `PBC_ST_DEEP); // RULE_03 RULE_05
            sram_retain         <= (state_next == `PBC_ST_DEEP); // RULE_05
            warm_boot           <= (state_next == `PBC_ST_WARM); // RULE_07
        end
    end

    // ------------------------------------------------------------------
    // Strap capture and boot sequence
    // ------------------------------------------------------------------
    reg  [2:0] boot_reg;
    reg  [2:0] boot_next;
    wire       flash_sel = strap_done_reg ? ~host_reg : ~strap_host_boot;

    always @* begin
        boot_next = boot_reg;
        case (boot_reg)
            `PBC_BT_IDLE:     boot_next = `PBC_BT_APPLET; // RULE_11
            `PBC_BT_APPLET:   if (applet_done) boot_next = `PBC_BT_IMAGE; // RULE_13
            `PBC_BT_IMAGE:    if (image_done) boot_next = `PBC_BT_HANDOVER; // RULE_13
            `PBC_BT_HANDOVER: boot_next = `PBC_BT_RUN; // RULE_13
            `PBC_BT_RUN:      boot_next = `PBC_BT_RUN;
            default:          boot_next = `PBC_BT_IDLE;
        endcase
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            strap_done_reg  <= 1'b0;
            host_reg        <= 1'b0;
            boot_reg        <= `PBC_BT_IDLE;
            boot_phase      <= `PBC_BT_IDLE;
            boot_from_flash <= 1'b0;
            flash_cs_n      <= 1'b1;
            flash_fetch_en  <= 1'b0;
            mgmt_msg_accept <= 1'b0;
            cpu_release     <= 1'b0;
            ser_spi_en      <= 1'b0;
            ser_uart_en     <= 1'b0;
            ser_gpio_en     <= 1'b0;
        end else begin
            // Host boot strap caught once on the first edge after reset release; serial select strap followed every cycle
            if (!strap_done_reg) begin
                strap_done_reg <= 1'b1;
                host_reg       <= strap_host_boot; // RULE_10
            end
            boot_reg        <= boot_next;
            boot_phase      <= boot_next;
            boot_from_flash <= flash_sel; // RULE_10
            // Single chip select, only driven while flash boot loads
            flash_fetch_en  <= flash_sel && ((boot_next == `PBC_BT_APPLET) ||
                               (boot_next == `PBC_BT_IMAGE)); // RULE_11 RULE_14
            flash_cs_n      <= ~(flash_sel && ((boot_next == `PBC_BT_APPLET) ||
                               (boot_next == `PBC_BT_IMAGE))); // RULE_14
            mgmt_msg_accept <= ~flash_sel && mgmt_msg_valid &&
                               ((boot_reg == `PBC_BT_APPLET) ||
                                (boot_reg == `PBC_BT_IMAGE)); // RULE_12
            cpu_release     <= (boot_next == `PBC_BT_RUN) &&
                               (state_next == `PBC_ST_ACTIVE); // RULE_13
            // One-hot pin function select; unknown codes pick nothing
            ser_spi_en      <= (strap_serial_sel == `PBC_SER_SPI);  // RULE_15
            ser_uart_en     <= (strap_serial_sel == `PBC_SER_UART); // RULE_15
            ser_gpio_en     <= (strap_serial_sel == `PBC_SER_GPIO); // RULE_15
        end
    end
endmodule // pbc_power_boot

// ==== pbc_sva.sv ====
// Purpose: Port assertions for the power state and boot control unit
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Counters bound the long waits; slack of one cycle on each
`timescale 1ns/10ps
`include "pbc_regs.vh"
module pbc_sva #(
    parameter         N_WAKE       = 4,
    parameter integer ENTER_CYCLES = `PBC_ENTER_CYCLES,
    parameter integer WARM_CYCLES  = `PBC_WARM_CYCLES
) (
    // Requests and wake sources
    input wire logic              clock, rst_n, sleep_req, deep_req, traffic_idle,
    input wire logic              host_wake, timer_wake, applet_done,
    input wire logic [N_WAKE-1:0] wake_pin,
    // Island control and boot
    input wire logic              island_gated_pwr_on, lp_clk_en, gated_clk_en, phy_pwr_on,
    input wire logic              mac_pwr_on, sram_retain, boot_from_flash, flash_cs_n,
    input wire logic              warm_boot, ser_spi_en, ser_uart_en, ser_gpio_en,
    input wire logic [2:0]        power_state, boot_phase
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    integer enter_cnt;
    integer warm_cnt;
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            enter_cnt <= 0;
            warm_cnt  <= 0;
        end else begin
            enter_cnt <= (power_state == `PBC_ST_ENTER) ? enter_cnt + 1 : 0;
            warm_cnt  <= (power_state == `PBC_ST_WARM) ? warm_cnt + 1 : 0;
        end
    end
    sequence s_applet_end;
        boot_phase == `PBC_BT_APPLET && applet_done;
    endsequence
    a_req_enter: assert property (power_state == `PBC_ST_ACTIVE &&
        (sleep_req || deep_req || traffic_idle) |=> power_state == `PBC_ST_ENTER)
        else $error("sleep request not taken");
    a_enter_bound: assert property (enter_cnt <= ENTER_CYCLES + 1)
        else $error("sleep entry too long");
    a_sleep_gating: assert property (power_state == `PBC_ST_SLEEP |-> !lp_clk_en &&
        !gated_clk_en && !phy_pwr_on && mac_pwr_on && island_gated_pwr_on)
        else $error("sleep gating wrong");
    a_deep_off: assert property (power_state == `PBC_ST_DEEP |->
        !island_gated_pwr_on && !mac_pwr_on && sram_retain) else $error("deep sleep power wrong");
    a_timer_wake: assert property ((power_state == `PBC_ST_SLEEP ||
        power_state == `PBC_ST_DEEP) && timer_wake |=> power_state == `PBC_ST_WARM && warm_boot)
        else $error("timer wake missed");
    a_deep_no_host: assert property (power_state == `PBC_ST_DEEP && host_wake &&
        !timer_wake && $past(wake_pin, 3) == $past(wake_pin, 4) |=> power_state == `PBC_ST_DEEP)
        else $error("host woke deep sleep");
    a_pin_wake: assert property (power_state == `PBC_ST_SLEEP && $changed(wake_pin)
        |-> ##[2:6] power_state == `PBC_ST_WARM) else $error("pin wake missed");
    a_warm_len: assert property (warm_cnt <= WARM_CYCLES + 1)
        else $error("warm boot too long");
    a_boot_order: assert property (s_applet_end |=> boot_phase == `PBC_BT_IMAGE)
        else $error("image load not next");
    a_flash_cs_use: assert property (!flash_cs_n |-> boot_from_flash &&
        (boot_phase == `PBC_BT_APPLET || boot_phase == `PBC_BT_IMAGE))
        else $error("flash select outside flash boot");
    a_serial_one: assert property ($onehot0({ser_spi_en, ser_uart_en, ser_gpio_en}))
        else $error("serial functions overlap");
endmodule // pbc_sva

// ==== pbc_boot_src.sv ====
// Purpose: Far-side model: flash or host finishing each boot load
// Assumes: Loads finish after a short or long delay chosen by slow
// Notes:   Host sends a packet every other cycle only while loading
`timescale 1ns/10ps
`include "pbc_regs.vh"
module pbc_boot_src (
    // Clock and control
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       slow,
    input  wire logic       strap_host_boot,
    input  wire logic [2:0] boot_phase,
    // Load progress
    output wire logic       applet_done,
    output wire logic       image_done,
    output wire logic       mgmt_msg_valid
);
    logic [4:0] cnt_reg;
    wire loading = boot_phase == `PBC_BT_APPLET || boot_phase == `PBC_BT_IMAGE;
    wire fin     = loading && cnt_reg == (slow ? 5'h14 : 5'h03);
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n)
            cnt_reg <= 5'h00;
        else
            cnt_reg <= (loading && !fin) ? cnt_reg + 5'h01 : 5'h00;
    end
    assign applet_done    = fin && boot_phase == `PBC_BT_APPLET;
    assign image_done     = fin && boot_phase == `PBC_BT_IMAGE;
    assign mgmt_msg_valid = strap_host_boot && loading && cnt_reg[0];
endmodule // pbc_boot_src

// ==== tb.sv ====
// Purpose: Self-checking bench for the power state and boot control unit
// Assumes: 40 MHz clock, inputs driven on the falling edge
// Notes:   Entry timeout shortened to 20 cycles to keep the run short
`timescale 1ns/10ps
`include "pbc_regs.vh"
module tb;
    localparam integer ENTER_C = 20;
    localparam integer WARM_C  = 64;
    logic       clock, rst_n, strap_host_boot, sleep_req, deep_req, traffic_idle;
    logic       enter_done, host_wake, timer_wake, slow, saw_acc, saw_cs;
    logic [1:0] strap_serial_sel;
    logic [3:0] wake_pin;
    wire        applet_done, image_done, mgmt_msg_valid, island_gated_pwr_on, lp_clk_en;
    wire        gated_clk_en, phy_pwr_on, mac_pwr_on, sram_retain, boot_from_flash;
    wire        flash_cs_n, flash_fetch_en, mgmt_msg_accept, cpu_release, warm_boot;
    wire        ser_spi_en, ser_uart_en, ser_gpio_en;
    wire [2:0]  power_state, boot_phase;
    wire [5:0]  pwr = {island_gated_pwr_on, lp_clk_en, gated_clk_en, phy_pwr_on,
                       mac_pwr_on, sram_retain};
    integer     n_fail, num_checks, i, j, k;
    integer     cycles = 0;
    pbc_power_boot #(.N_WAKE(4), .ENTER_CYCLES(ENTER_C), .WARM_CYCLES(WARM_C)) dut (.*);
    pbc_boot_src u_src (.*);
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    task print_verdict;
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Pin watch and hang limit
    always @(posedge clock) begin
        if (mgmt_msg_accept === 1'b1) saw_acc <= 1'b1;
        if (flash_cs_n === 1'b0) saw_cs <= 1'b1;
        cycles = cycles + 1;
        if (cycles == 5000) begin
            n_fail = n_fail + 1;
            print_verdict();
        end
    end
    task chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("CHECK FAILED t=%0t %s", $time, msg);
        end
    endtask
    function logic [5:0] exp_pwr(input logic [2:0] st);
        case (st)
            `PBC_ST_SLEEP: exp_pwr = 6'h22;
            `PBC_ST_DEEP:  exp_pwr = 6'h01;
            default:       exp_pwr = 6'h3e;
        endcase
    endfunction
    task do_reset(input logic hb, input logic [1:0] sel);
        rst_n = 1'b0;
        strap_host_boot = hb;
        strap_serial_sel = sel;
        slow = 1'($urandom % 2);
        repeat (10) @(negedge clock);
        chk(power_state, `PBC_ST_ACTIVE, "reset state");
        chk(pwr, 6'h3e, "reset power");
        saw_acc = 1'b0;
        saw_cs = 1'b0;
        rst_n = 1'b1;
        @(negedge clock);
        chk(boot_phase, `PBC_BT_APPLET, "boot start");
        chk(flash_cs_n, hb, "flash select");
        chk({flash_fetch_en, boot_from_flash}, {2{!hb}}, "flash fetch");
        chk({ser_spi_en, ser_uart_en, ser_gpio_en}, sel == 2'h3 ? 3'h0 : 3'h4 >> sel, "ser");
        for (k = 0; cpu_release !== 1'b1 && k < 200; k++) @(negedge clock);
        chk(boot_phase, `PBC_BT_RUN, "boot run");
        chk(saw_acc, hb, "packets taken");
        chk(saw_cs, !hb, "flash used");
    endtask
    task power_cycle(input integer kind, input integer src, input logic use_done);
        logic [2:0] st;
        st = (kind == 1) ? `PBC_ST_DEEP : `PBC_ST_SLEEP;
        {traffic_idle, deep_req, sleep_req} = 3'h1 << kind;
        @(negedge clock);
        {traffic_idle, deep_req, sleep_req} = 3'h0;
        chk(power_state, `PBC_ST_ENTER, "enter");
        enter_done = use_done;
        for (k = 0; power_state === `PBC_ST_ENTER && k < ENTER_C + 2; k++) begin
            @(negedge clock);
            enter_done = 1'b0;
        end
        chk(power_state, st, "asleep");
        chk(pwr, exp_pwr(st), "islands");
        chk({cpu_release, warm_boot}, 2'h0, "asleep flags");
        if (kind == 1) begin
            host_wake = 1'b1;
            @(negedge clock);
            host_wake = 1'b0;
            @(negedge clock);
            chk(power_state, st, "host ignored");
        end
        if (src == 2) wake_pin = wake_pin ^ (4'h1 << ($urandom % 4));
        else if (src == 0 && kind != 1) host_wake = 1'b1;
        else timer_wake = 1'b1;
        for (k = 0; power_state !== `PBC_ST_WARM && k < 8; k++) begin
            @(negedge clock);
            {host_wake, timer_wake} = 2'h0;
        end
        chk(src == 2 ? (k > 2 && k < 7) : k == 1, 1'b1, "wake delay");
        chk(warm_boot, 1'b1, "warm boot");
        chk(pwr, 6'h3e, "islands back");
        for (k = 0; power_state !== `PBC_ST_ACTIVE && k < WARM_C + 8; k++) @(negedge clock);
        chk(power_state, `PBC_ST_ACTIVE, "active again");
    endtask
    initial begin
        n_fail = 0;
        num_checks = 0;
        rst_n = 1'b0;
        {strap_host_boot, sleep_req, deep_req, traffic_idle} = 4'h0;
        {enter_done, host_wake, timer_wake, slow} = 4'h0;
        strap_serial_sel = 2'h0;
        wake_pin = 4'h0;
        void'($urandom(89));
        for (i = 0; i < 4; i++) begin
            do_reset(i[0], i[1:0]);
            for (j = 0; j < 3; j++) power_cycle(j, (i + j) % 3, 1'($urandom % 2));
        end
        print_verdict();
    end
endmodule // tb
bind pbc_power_boot pbc_sva #(.N_WAKE(N_WAKE), .ENTER_CYCLES(ENTER_CYCLES),
    .WARM_CYCLES(WARM_CYCLES)) u_sva (.*);
